// File: core/rsc_consts.vh
`ifndef RSC_CONSTS_VH
`define RSC_CONSTS_VH
`define RSC_CFG_OFS        8'h00
`define RSC_STAT_OFS       8'h04
`define RSC_CAUSE_OFS      8'h08
`define RSC_CFG_ERASED     14'h3fff
`define RSC_CFG_IMPL       14'h007f
`define RSC_CFG_OSC_LSB    0
`define RSC_CFG_POWER_UP_TIMER_BIT   3
`define RSC_CFG_PIN_BIT    5
`define RSC_CFG_BOR_BIT    6
`define RSC_STAT_TO_BIT    0
`define RSC_STAT_PD_BIT    1
`define RSC_STAT_POR_BIT   2
`define RSC_STAT_BOR_BIT   3
`define RSC_STAT_RESET     4'h3
`define RSC_CAUSE_POR      6'h01
`define RSC_CAUSE_PIN_RUN  6'h02
`define RSC_CAUSE_PIN_SLP  6'h04
`define RSC_CAUSE_WDT_RST  6'h08
`define RSC_CAUSE_WDT_WAKE 6'h10
`define RSC_CAUSE_BOR      6'h20
`define RSC_CLK_MHZ        100
`define RSC_POWER_UP_TIMER_MS        72
`define RSC_CPU_START_NS   5000
`define RSC_FILTER_NS      200
`define RSC_OST_CYCLES     1024
`endif

// File: core/rsc_reset_control.v
`timescale 1ns/1ps
`default_nettype none
`include "rsc_consts.vh"
module rsc_reset_control #(
    parameter integer POWER_UP_TIMER_CYCLES = `RSC_POWER_UP_TIMER_MS * `RSC_CLK_MHZ * 1000
)(
    // Clock, reset, enable
    input  wire        pclk,
    input  wire        presetn,
    input  wire        clk_en,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Pin and supply monitor
    input  wire        master_clear_pin,
    output reg         master_clear_pin_oe,
    input  wire        supply_ok,
    input  wire        brownout_detect,
    // Oscillator and CPU side
    input  wire        osc_tick,
    input  wire        sleep_mode,
    input  wire        watchdog_timeout,
    output reg         cpu_hold,
    output reg         reg_init,
    output reg         wake_resume,
    output reg         port_a_bit_five
);

    localparam integer CPU_CYC = (`RSC_CPU_START_NS * `RSC_CLK_MHZ + 999) / 1000;
    localparam integer FLT_CYC = (`RSC_FILTER_NS * `RSC_CLK_MHZ + 999) / 1000;

    localparam [3:0] S_RUN  = 4'b0001;
    localparam [3:0] S_POWER_UP_TIMER = 4'b0010;
    localparam [3:0] S_OST  = 4'b0100;
    localparam [3:0] S_HOLD = 4'b1000;

    function is_crystal;
        input [2:0] osc;
        begin
            is_crystal = (osc < 3'd3);
        end
    endfunction

    reg [13:0] cfg;
    reg [3:0]  stat;
    reg [5:0]  cause;
    reg [3:0]  state;
    reg [22:0] power_up_timer_cnt;
    reg [10:0] ost_cnt;
    reg [15:0] cpu_cnt;
    reg [7:0]  flt_cnt;
    reg        pin_meta;
    reg        pin_s;
    reg        sup_meta;
    reg        sup_s;
    reg        sup_q;
    reg        bo_meta;
    reg        bo_s;
    reg        bor_q;
    reg        pin_rst_q;
    reg        need_timers;
    reg        waking;

    wire       pin_mode   = cfg[`RSC_CFG_PIN_BIT];
    wire       power_up_timer_en    = ~cfg[`RSC_CFG_POWER_UP_TIMER_BIT];
    wire       xtal       = is_crystal(cfg[`RSC_CFG_OSC_LSB +: 3]);
    wire       bor_active = cfg[`RSC_CFG_BOR_BIT] & bo_s;
    wire       pin_rst    = pin_mode & (flt_cnt == FLT_CYC[7:0]);
    wire       por_ev     = sup_s & ~sup_q;
    wire       bor_ev     = bor_active & ~bor_q;
    wire       pin_ev     = pin_rst & ~pin_rst_q;
    wire       supply_bad = ~sup_s | bor_active;
    wire       wr         = psel & penable & pwrite & pready;
    wire [31:0] cfg_rd    = {18'h0, cfg | ~`RSC_CFG_IMPL};

    // Two-flop synchronisers for pin and monitor inputs
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_meta <= 1'b1;
            pin_s    <= 1'b1;
            sup_meta <= 1'b0;
            sup_s    <= 1'b0;
            bo_meta  <= 1'b0;
            bo_s     <= 1'b0;
        end
        else if (clk_en)
        begin
            pin_meta <= master_clear_pin;
            pin_s    <= pin_meta;
            sup_meta <= supply_ok;
            sup_s    <= sup_meta;
            bo_meta  <= brownout_detect;
            bo_s     <= bo_meta;
        end
    end

    // APB slave: no wait states, errors on unmapped addresses
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end
        else if (clk_en)
        begin
            pready  <= psel & ~penable;
            pslverr <= 1'b0;
            if (psel & ~penable)
            begin
                case (paddr)
                    `RSC_CFG_OFS:   prdata <= cfg_rd;
                    `RSC_STAT_OFS:  prdata <= {28'h0, stat};
                    `RSC_CAUSE_OFS: prdata <= {26'h0, cause};
                    default:
                    begin
                        prdata  <= 32'h0;
                        pslverr <= 1'b1;
                    end
                endcase
            end
        end
    end

    // Configuration word
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cfg <= `RSC_CFG_ERASED;
        else if (clk_en && wr && paddr == `RSC_CFG_OFS)
            cfg <= (pwdata[13:0] & `RSC_CFG_IMPL) | ~`RSC_CFG_IMPL;
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flt_cnt <= 8'h0;
        else if (clk_en)
        begin
            if (pin_s || !pin_mode)
                flt_cnt <= 8'h0;
            else if (flt_cnt != FLT_CYC[7:0])
                flt_cnt <= flt_cnt + 8'h1;
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            port_a_bit_five     <= 1'b0;
            master_clear_pin_oe <= 1'b0;
        end
        else if (clk_en)
        begin
            port_a_bit_five     <= pin_mode ? 1'b0 : pin_s;
            master_clear_pin_oe <= 1'b0;
        end
    end

    // Status flags and cause; hardware events win over software writes
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stat  <= `RSC_STAT_RESET;
            cause <= `RSC_CAUSE_POR;
        end
        else if (clk_en)
        begin
            if (wr && paddr == `RSC_STAT_OFS)
            begin
                stat[`RSC_STAT_POR_BIT] <= pwdata[`RSC_STAT_POR_BIT];
                stat[`RSC_STAT_BOR_BIT] <= pwdata[`RSC_STAT_BOR_BIT];
            end
            if (por_ev)
            begin
                stat  <= `RSC_STAT_RESET;
                cause <= `RSC_CAUSE_POR;
            end
            else if (bor_ev)
            begin
                stat[`RSC_STAT_TO_BIT]  <= 1'b1;
                stat[`RSC_STAT_PD_BIT]  <= 1'b1;
                stat[`RSC_STAT_BOR_BIT] <= 1'b0;
                cause <= `RSC_CAUSE_BOR;
            end
            else if (pin_ev && sleep_mode && state == S_RUN)
            begin
                stat[`RSC_STAT_TO_BIT] <= 1'b1;
                stat[`RSC_STAT_PD_BIT] <= 1'b0;
                cause <= `RSC_CAUSE_PIN_SLP;
            end
            else if (pin_ev && state == S_RUN)
                cause <= `RSC_CAUSE_PIN_RUN;
            else if (watchdog_timeout && state == S_RUN)
            begin
                stat[`RSC_STAT_TO_BIT] <= 1'b0;
                stat[`RSC_STAT_PD_BIT] <= ~sleep_mode;
                cause <= sleep_mode ? `RSC_CAUSE_WDT_WAKE : `RSC_CAUSE_WDT_RST;
            end
        end
    end

    // Sequencer: hold, power-up timer, oscillator start-up, run
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state       <= S_HOLD;
            need_timers <= 1'b1;
            waking      <= 1'b0;
            power_up_timer_cnt    <= 23'h0;
            ost_cnt     <= 11'h0;
            cpu_cnt     <= 16'h0;
            sup_q       <= 1'b0;
            bor_q       <= 1'b0;
            pin_rst_q   <= 1'b0;
            cpu_hold    <= 1'b1;
            reg_init    <= 1'b1;
            wake_resume <= 1'b0;
        end
        else if (clk_en)
        begin
            sup_q       <= sup_s;
            bor_q       <= bor_active;
            pin_rst_q   <= pin_rst;
            wake_resume <= 1'b0;
            if (cpu_cnt != 16'h0)
                cpu_cnt <= cpu_cnt - 16'h1;
            if (supply_bad)
            begin
                state       <= S_HOLD;
                need_timers <= 1'b1;
                waking      <= 1'b0;
                cpu_hold    <= 1'b1;
                reg_init    <= 1'b1;
            end
            else if (pin_ev)
            begin
                if (state == S_RUN)
                    state <= S_HOLD;
                waking   <= 1'b0;
                cpu_hold <= 1'b1;
                reg_init <= 1'b1;
            end
            else
            begin
                case (state)
                    S_RUN:
                    begin
                        if (watchdog_timeout && sleep_mode)
                        begin
                            waking   <= 1'b1;
                            cpu_hold <= 1'b1;
                            cpu_cnt  <= CPU_CYC[15:0];
                            ost_cnt  <= 11'h0;
                            state    <= xtal ? S_OST : S_HOLD;
                        end
                        else if (watchdog_timeout)
                        begin
                            cpu_hold <= 1'b1;
                            reg_init <= 1'b1;
                            state    <= S_HOLD;
                        end
                    end
                    S_POWER_UP_TIMER:
                    begin
                        if (power_up_timer_cnt != 23'h0)
                            power_up_timer_cnt <= power_up_timer_cnt - 23'h1;
                        else
                        begin
                            ost_cnt <= 11'h0;
                            state   <= xtal ? S_OST : S_HOLD;
                        end
                    end
                    S_OST:
                    begin
                        if (ost_cnt == `RSC_OST_CYCLES)
                            state <= S_HOLD;
                        else if (osc_tick)
                            ost_cnt <= ost_cnt + 11'h1;
                    end
                    S_HOLD:
                    begin
                        if (need_timers)
                        begin
                            need_timers <= 1'b0;
                            cpu_cnt     <= CPU_CYC[15:0];
                            power_up_timer_cnt    <= power_up_timer_en ? POWER_UP_TIMER_CYCLES[22:0] : 23'h0;
                            state       <= S_POWER_UP_TIMER;
                        end
                        // run once pin and delays clear
                        else if (!pin_rst && cpu_cnt == 16'h0)
                        begin
                            state       <= S_RUN;
                            cpu_hold    <= 1'b0;
                            reg_init    <= 1'b0;
                            wake_resume <= waking;
                            waking      <= 1'b0;
                        end
                    end
                    default:
                    begin
                        state       <= S_HOLD;
                        need_timers <= 1'b1;
                    end
                endcase
            end
        end
    end

endmodule // rsc_reset_control
`default_nettype wire

// File: sim/rsc_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module rsc_pin_model (
    // Clock
    input  wire logic pclk,
    // Pin, supply and oscillator
    output logic      pin,
    output logic      supply,
    output logic      brown,
    output logic      tick
);
    int div = 0;
    // Pin idles high through its pull-up network
    initial
    begin
        pin = 1;
        supply = 0;
        brown = 0;
        tick = 0;
    end
    // Oscillator runs free, one pulse per four cycles
    always @(posedge pclk)
    begin
        div <= div + 1;
        tick <= (div % 4 == 3);
    end
    task set_pin(input logic v);
        pin <= v;
    endtask
    task pin_low(input int n);
    begin
        pin <= 0;
        repeat (n) @(posedge pclk);
        pin <= 1;
    end
    endtask
    task supply_up();
    begin
        repeat (10) @(posedge pclk);
        supply <= 1;
    end
    endtask
    task brown_out(input int n);
    begin
        brown <= 1;
        repeat (n) @(posedge pclk);
        brown <= 0;
    end
    endtask
endmodule // rsc_pin_model
`default_nettype wire

// File: sim/rsc_reset_control_props.sv
`timescale 1ns/1ps
`default_nettype none
module rsc_reset_control_props (
    input wire logic pclk, presetn, clk_en, psel, penable, pready, pslverr,
    input wire logic master_clear_pin, master_clear_pin_oe, supply_ok, brownout_detect,
    input wire logic sleep_mode, watchdog_timeout, cpu_hold, reg_init
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [9:0] low_cnt;
    // Saturates so a long hold cannot wrap back under the filter figure
    always @(posedge pclk or negedge presetn)
        if (!presetn) low_cnt <= 10'h0;
        else if (master_clear_pin) low_cnt <= 10'h0;
        else if (low_cnt != 10'h3ff) low_cnt <= low_cnt + 10'h1;
    property p_oe; !master_clear_pin_oe; endproperty
    a_oe: assert property (p_oe) else $error("pin driven");
    property p_ready; psel && !penable && clk_en |=> pready; endproperty
    a_ready: assert property (p_ready) else $error("no ready");
    property p_one; pready |=> !pready; endproperty
    a_one: assert property (p_one) else $error("ready stuck");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("error without ready");
    property p_wdt;
        watchdog_timeout && !sleep_mode && !cpu_hold && clk_en && master_clear_pin
        |=> cpu_hold && reg_init;
    endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog reset missed");
    property p_wake;
        watchdog_timeout && sleep_mode && !cpu_hold && clk_en
        |=> (cpu_hold && !reg_init) [*8];
    endproperty
    a_wake: assert property (p_wake) else $error("wake initialised");
    property p_filter;
        $rose(cpu_hold) && !$past(watchdog_timeout) && !brownout_detect |-> low_cnt >= 10'd20;
    endproperty
    a_filter: assert property (p_filter) else $error("short pulse reset");
    property p_release;
        $rose(master_clear_pin) && low_cnt > 10'd700 && supply_ok |-> ##[1:4] !cpu_hold;
    endproperty
    a_release: assert property (p_release) else $error("late start");
    property p_power_up_timer; $rose(supply_ok) |=> cpu_hold [*8]; endproperty
    a_power_up_timer: assert property (p_power_up_timer) else $error("early start");
endmodule // rsc_reset_control_props
bind rsc_reset_control rsc_reset_control_props u_props (.pclk, .presetn, .clk_en, .psel,
    .penable, .pready, .pslverr, .master_clear_pin, .master_clear_pin_oe, .supply_ok,
    .brownout_detect, .sleep_mode, .watchdog_timeout, .cpu_hold, .reg_init);
`default_nettype wire

// File: sim/rsc_reset_control_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "rsc_consts.vh"
module rsc_reset_control_test;
    logic        pclk = 0, presetn = 0, clk_en, psel, penable, pwrite;
    logic        sleep_mode, watchdog_timeout, e, ri;
    logic [7:0]  paddr;
    logic [31:0] pwdata, r;
    wire logic [31:0] prdata;
    wire logic   pready, pslverr, master_clear_pin_oe, cpu_hold, reg_init, wake_resume;
    wire logic   port_a_bit_five, master_clear_pin, supply_ok, brownout_detect, osc_tick;
    int          errors = 0, compares = 0, cyc = 0, n;
    logic [5:0]  exp_cause [5] = '{`RSC_CAUSE_PIN_RUN, `RSC_CAUSE_PIN_SLP,
                                   `RSC_CAUSE_WDT_RST, `RSC_CAUSE_WDT_WAKE, `RSC_CAUSE_BOR};
    logic [3:0]  exp_stat [5] = '{4'hf, 4'hd, 4'he, 4'hc, 4'h7};
    always #5 pclk = ~pclk;
    rsc_reset_control #(.POWER_UP_TIMER_CYCLES(50)) DUT (.pclk, .presetn, .clk_en, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .master_clear_pin,
        .master_clear_pin_oe, .supply_ok, .brownout_detect, .osc_tick, .sleep_mode,
        .watchdog_timeout, .cpu_hold, .reg_init, .wake_resume, .port_a_bit_five);
    rsc_pin_model PM (.pclk, .pin(master_clear_pin), .supply(supply_ok),
        .brown(brownout_detect), .tick(osc_tick));
    task stop_test();
    begin
        if (errors == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
    endtask
    task chk(input logic [31:0] s, input logic [31:0] x);
    begin
        compares++;
        if (s !== x)
        begin
            errors++;
            $display("BAD %0t seen %h expected %h", $time, s, x);
        end
    end
    endtask
    // Entered just after a rising edge; pready sampled before that edge's updates land
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    begin
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    end
    endtask
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            errors++;
            stop_test();
        end
    end
    initial
    begin
        clk_en <= 1;
        psel <= 0;
        penable <= 0;
        pwrite <= 0;
        paddr <= 8'h00;
        pwdata <= 32'h0;
        sleep_mode <= 0;
        watchdog_timeout <= 0;
        repeat (6) @(posedge pclk);
        presetn <= 1;
        PM.set_pin(0);
        PM.supply_up();
        repeat (800) @(posedge pclk);
        PM.set_pin(1);
        n = 0;
        while (cpu_hold !== 1'b0 && n < 20) begin @(posedge pclk); n++; end
        // Two sync flops, filter clear, sequencer: low after edge four, seen at edge five
        chk(n, 5);
        apb(0, `RSC_CFG_OFS, 0); chk(r, 32'h3fff);
        apb(0, `RSC_STAT_OFS, 0); chk(r & 32'h7, 32'h3);
        apb(0, `RSC_CAUSE_OFS, 0); chk(r, `RSC_CAUSE_POR);
        apb(1, `RSC_CFG_OFS, 0);
        apb(0, `RSC_CFG_OFS, 0); chk(r, 32'h3f80);
        apb(1, `RSC_CFG_OFS, 32'h3fff);
        apb(1, 8'h0c, 32'h5); chk(e, 1);
        apb(0, 8'h0c, 0); chk({e, r}, {1'b1, 32'h0});
        apb(1, `RSC_STAT_OFS, 32'hc);
        PM.pin_low(12);
        repeat (30) @(posedge pclk);
        chk(cpu_hold, 0);
        for (int k = 0; k < 5; k++)
        begin
            sleep_mode <= (k == 1 || k == 3);
            @(posedge pclk);
            if (k < 2) PM.pin_low(40);
            else if (k < 4)
            begin
                watchdog_timeout <= 1;
                @(posedge pclk);
                watchdog_timeout <= 0;
            end
            else PM.brown_out(40);
            sleep_mode <= 0;
            n = 0;
            ri = 0;
            while ((k == 3 ? wake_resume : !cpu_hold) !== 1'b1 && n < 3000)
            begin
                @(posedge pclk);
                n++;
                ri |= reg_init;
            end
            if (k == 3) chk(ri, 0);
            if (k > 2) chk(n >= 450 && n <= 1100, 1);
            apb(0, `RSC_CAUSE_OFS, 0); chk(r, exp_cause[k]);
            apb(0, `RSC_STAT_OFS, 0); chk(r, exp_stat[k]);
        end
        // Crystal mode with power-up timer on: brownout runs both start-up counts
        apb(1, `RSC_CFG_OFS, 32'h3fe0);
        PM.brown_out(40);
        n = 0;
        while (cpu_hold !== 1'b0 && n < 6000) begin @(posedge pclk); n++; end
        // Model ticks once per four cycles; the bench timer is 50 cycles
        chk(n >= 50 + 4 * `RSC_OST_CYCLES && n <= 150 + 4 * `RSC_OST_CYCLES, 1);
        // Frozen enable: a long pin pulse must go unseen
        clk_en <= 0;
        PM.pin_low(40);
        chk(cpu_hold, 0);
        clk_en <= 1;
        apb(1, `RSC_CFG_OFS, 32'h3fdf);
        PM.set_pin(0);
        repeat (40) @(posedge pclk);
        chk({cpu_hold, port_a_bit_five}, 0);
        PM.set_pin(1);
        repeat (4) @(posedge pclk);
        chk(port_a_bit_five, 1);
        stop_test();
    end
endmodule // rsc_reset_control_test
`default_nettype wire
